/* src/dist_config_id_regs.sv */
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Function
// - no-one-of-many bit reads zero
// - affinity level 3 bit follows build
// - identifier width field reads 0b01111
// - direct virtual injection bit reads zero
// - locality interrupt bit follows build
// - message interrupt bit reads one
// - locality count field reads zero
// - security bit follows build
// - disable security forces security bit zero
// - processor count field reads zero
// - line count field holds N
// - fixed product and implementer codes
// - variant code in bits 19:16
// - minor revision code in bits 15:12
// - scrub control acts on local RAMs
// - disable security resets from parameter
// - affinity routing bits read one
module dist_config_id_regs #(
    parameter logic a3v_cfg = 1'b0,
    parameter logic lpi_cfg = 1'b1,
    parameter logic two_sec_cfg = 1'b1,
    parameter logic [4:0] lines_cfg = 5'h1f,
    parameter dist_id_pkg::ds_mode_e security_disable_param = dist_id_pkg::ds_zero,
    // identity values are arbitrary
    parameter logic [7:0] product_code = 8'h5a,
    parameter logic [3:0] variant_code = 4'h0,
    parameter logic [3:0] revision_code = 4'h2,
    parameter logic [11:0] implementer_code = 12'h7e5
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // local ram scrub enable
    output logic scrub_enable
);
    // reset value of the security disable bit is a build choice
    localparam logic ds_rst = (security_disable_param == dist_id_pkg::ds_one);
    // security mode can only change when the build leaves it programmable
    localparam logic ds_wr_ok = (security_disable_param == dist_id_pkg::ds_prog);

    // true when the given address selects the given register word
    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] reg_addr);
        addr_hit = (addr == reg_addr);
    endfunction : addr_hit

    // one flag moved to its bit position in a register word
    function automatic logic [31:0] put_bit(input logic value, input int pos);
        put_bit = {31'h00000000, value} << pos;
    endfunction : put_bit

    // a field of up to twelve bits moved to its position in a register word
    function automatic logic [31:0] put_field(input logic [11:0] value, input int lsb);
        put_field = {20'h00000, value} << lsb;
    endfunction : put_field

    // type word is built in its own module; it needs the security disable bit back
    dist_reg_if rif ();

    dist_type_word #(
        .a3v_cfg(a3v_cfg),
        .lpi_cfg(lpi_cfg),
        .two_sec_cfg(two_sec_cfg),
        .lines_cfg(lines_cfg)
    ) u_type (
        .rif(rif.prov)
    );

    // register state
    logic ds_q;
    logic ds_d;
    logic [31:0] fctl_q;
    logic [31:0] fctl_d;
    // bus answer state
    logic ready_q;
    logic ready_d;
    logic [31:0] prdata_d;
    logic slverr_d;
    logic scrub_d;
    // write targets held from the setup cycle
    logic sel_ctrl_q;
    logic sel_ctrl_d;
    logic sel_fctl_q;
    logic sel_fctl_d;

    // setup cycle latches the answer; the access cycle after it completes with no wait state
    wire setup = psel & ~penable;
    wire access = psel & penable & ready_q;
    wire wr = access & pwrite;

    // address decode for the setup cycle
    wire hit_ctrl = addr_hit(paddr, dist_id_pkg::ctrl_addr);
    wire hit_type = addr_hit(paddr, dist_id_pkg::type_addr);
    wire hit_iid = addr_hit(paddr, dist_id_pkg::iid_addr);
    wire hit_fctl = addr_hit(paddr, dist_id_pkg::fctl_addr);
    wire mapped = hit_ctrl | hit_type | hit_iid | hit_fctl;
    // a write acts on the word chosen in setup, not on whatever the address shows later
    assign sel_ctrl_d = setup ? hit_ctrl : sel_ctrl_q;
    assign sel_fctl_d = setup ? hit_fctl : sel_fctl_q;

    // control word: only the security disable bit is stored, routing enables are tied
    wire [31:0] ctrl_ds_part = put_bit(ds_q, dist_id_pkg::ctrl_ds_bit);
    wire [31:0] ctrl_affinity_routing_nonsecure_part = put_bit(1'b1, dist_id_pkg::ctrl_affinity_routing_nonsecure_bit);
    wire [31:0] ctrl_are_s_part = put_bit(1'b1, dist_id_pkg::ctrl_are_s_bit);
    wire [31:0] ctrl_word = ctrl_ds_part | ctrl_affinity_routing_nonsecure_part | ctrl_are_s_part;

    // security disable goes back so the security bit can read as zero
    assign rif.ds = ds_q;
    wire [31:0] type_word = rif.type_word;

    // identification word; bits 23:20 get nothing and read zero
    wire [31:0] iid_prod_part = put_field({4'h0, product_code}, dist_id_pkg::iid_prod_lsb);
    wire [31:0] iid_var_part = put_field({8'h00, variant_code}, dist_id_pkg::iid_var_lsb);
    wire [31:0] iid_rev_part = put_field({8'h00, revision_code}, dist_id_pkg::iid_rev_lsb);
    wire [31:0] iid_impl_part = put_field(implementer_code, dist_id_pkg::iid_impl_lsb);
    wire [31:0] iid_word = iid_prod_part | iid_var_part | iid_rev_part | iid_impl_part;

    // function control: only the scrub enable is held, other bits read zero
    wire [31:0] fctl_word = fctl_q & dist_id_pkg::fctl_mask;

    // type and identification words have no write strobe, so writes there do nothing
    wire wr_ctrl = wr & sel_ctrl_q;
    wire wr_fctl = wr & sel_fctl_q;
    wire ds_load = wr_ctrl & ds_wr_ok;
    assign ds_d = ds_load ? pwdata[dist_id_pkg::ctrl_ds_bit] : ds_q;
    // scrub control stays local; nothing here reaches other distributors
    assign fctl_d = wr_fctl ? (pwdata & dist_id_pkg::fctl_mask) : fctl_q;
    assign scrub_d = fctl_d[dist_id_pkg::fctl_scrub_bit];

    // read select as and-or of gated words; unmapped addresses read zero
    wire [31:0] rd_ctrl_part = hit_ctrl ? ctrl_word : 32'h00000000;
    wire [31:0] rd_type_part = hit_type ? type_word : 32'h00000000;
    wire [31:0] rd_iid_part = hit_iid ? iid_word : 32'h00000000;
    wire [31:0] rd_fctl_part = hit_fctl ? fctl_word : 32'h00000000;
    wire [31:0] rd_word = rd_ctrl_part | rd_type_part | rd_iid_part | rd_fctl_part;
    // loaded in setup only, so data, error and ready stand for the access cycle alone
    assign prdata_d = setup ? rd_word : 32'h00000000;
    assign slverr_d = setup & ~mapped;
    assign ready_d = setup;

    // security disable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ds_q <= ds_rst;
        end else begin
            ds_q <= ds_d;
        end
    end

    // function control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fctl_q <= 32'h00000000;
        end else begin
            fctl_q <= fctl_d;
        end
    end

    // held write targets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ctrl_q <= 1'b0;
            sel_fctl_q <= 1'b0;
        end else begin
            sel_ctrl_q <= sel_ctrl_d;
            sel_fctl_q <= sel_fctl_d;
        end
    end

    // one-cycle ready in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
        end
    end

    // read data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata <= prdata_d;
            pslverr <= slverr_d;
        end
    end

    // scrub enable follows the stored bit with no extra cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scrub_enable <= 1'b0;
        end else begin
            scrub_enable <= scrub_d;
        end
    end

    assign pready = ready_q;
endmodule : dist_config_id_regs

/* src/dist_id_pkg.sv */
package dist_id_pkg;
    // register byte addresses
    localparam logic [15:0] ctrl_addr = 16'h0000;
    localparam logic [15:0] type_addr = 16'h0004;
    localparam logic [15:0] iid_addr = 16'h0008;
    localparam logic [15:0] fctl_addr = 16'h0020;
    // control register fields
    localparam int ctrl_ds_bit = 6;
    localparam int ctrl_affinity_routing_nonsecure_bit = 5;
    localparam int ctrl_are_s_bit = 4;
    // type register fields
    localparam int ty_one_of_many_routing_absent_bit = 25;
    localparam int ty_a3v_bit = 24;
    localparam int ty_idw_lsb = 19;
    localparam int ty_direct_virtual_injection_bit = 18;
    localparam int ty_locality_interrupt_support_bit = 17;
    localparam int ty_message_interrupt_support_bit = 16;
    localparam int ty_nlpi_lsb = 11;
    localparam int ty_sec_bit = 10;
    localparam int ty_cpu_lsb = 5;
    localparam int ty_itl_lsb = 0;
    localparam logic [4:0] identifier_width_val = 5'h0f;
    localparam logic [4:0] locality_count_val = 5'h00;
    localparam logic [2:0] processor_count_val = 3'h0;
    // identification register fields
    localparam int iid_prod_lsb = 24;
    localparam int iid_var_lsb = 16;
    localparam int iid_rev_lsb = 12;
    localparam int iid_impl_lsb = 0;
    // function control scrub bit
    localparam int fctl_scrub_bit = 0;
    localparam logic [31:0] fctl_mask = 32'h00000001;
    // security_disable_param encodings
    typedef enum logic [1:0] {ds_zero, ds_one, ds_prog} ds_mode_e;
endpackage : dist_id_pkg

/* src/dist_reg_if.sv */
`timescale 1ns/100ps
interface dist_reg_if;
    logic ds;
    logic [31:0] type_word;
    modport prov (output type_word, input ds);
    modport user (input type_word, output ds);
endinterface : dist_reg_if

/* src/dist_type_word.sv */
`timescale 1ns/100ps
module dist_type_word #(
    parameter logic a3v_cfg = 1'b0,
    parameter logic lpi_cfg = 1'b1,
    parameter logic two_sec_cfg = 1'b1,
    parameter logic [4:0] lines_cfg = 5'h1f
) (
    dist_reg_if.prov rif
);
    always_comb begin
        rif.type_word = 32'h00000000;
        rif.type_word[dist_id_pkg::ty_one_of_many_routing_absent_bit] = 1'b0;
        rif.type_word[dist_id_pkg::ty_a3v_bit] = a3v_cfg;
        rif.type_word[dist_id_pkg::ty_idw_lsb +: 5] = dist_id_pkg::identifier_width_val;
        rif.type_word[dist_id_pkg::ty_direct_virtual_injection_bit] = 1'b0;
        rif.type_word[dist_id_pkg::ty_locality_interrupt_support_bit] = lpi_cfg;
        rif.type_word[dist_id_pkg::ty_message_interrupt_support_bit] = 1'b1;
        rif.type_word[dist_id_pkg::ty_nlpi_lsb +: 5] = dist_id_pkg::locality_count_val;
        // security bit reads as zero while security is disabled
        rif.type_word[dist_id_pkg::ty_sec_bit] = two_sec_cfg & ~rif.ds;
        rif.type_word[dist_id_pkg::ty_cpu_lsb +: 3] = dist_id_pkg::processor_count_val;
        rif.type_word[dist_id_pkg::ty_itl_lsb +: 5] = lines_cfg;
    end
endmodule : dist_type_word

/* verification/dist_config_id_regs_sva.sv */
`timescale 1ns/100ps
module dist_config_id_regs_sva #(
    parameter logic a3v_cfg = 1'h0,
    parameter logic lpi_cfg = 1'h1,
    parameter logic two_sec_cfg = 1'h1,
    parameter logic [4:0] lines_cfg = 5'h1f
) (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [15:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic scrub_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd = pready && !pwrite;
    wire rd_ty = rd && paddr == dist_id_pkg::type_addr;
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_type_fixed: assert property (rd_ty |-> prdata[25:11] == {1'h0, a3v_cfg, 5'h0f, 1'h0, lpi_cfg, 6'h20})
        else $error("type field wrong");
    a_type_lines: assert property (rd_ty |-> prdata[4:0] == lines_cfg) else $error("line count wrong");
    a_type_resv: assert property (rd_ty |-> prdata[31:26] == 6'h0 && prdata[9:5] == 5'h0)
        else $error("type reserved set");
    a_sec_cfg: assert property (rd_ty && prdata[10] |-> two_sec_cfg) else $error("security bit wrong");
    a_ctrl_route: assert property (rd && paddr == dist_id_pkg::ctrl_addr |-> prdata[5:4] == 2'h3)
        else $error("routing bits low");
    a_id_resv: assert property (rd && paddr == dist_id_pkg::iid_addr |-> prdata[23:20] == 4'h0)
        else $error("id reserved set");
    a_scrub_write: assert property (pready && pwrite && paddr == dist_id_pkg::fctl_addr
        |=> scrub_enable == $past(pwdata[0])) else $error("scrub not updated");
endmodule : dist_config_id_regs_sva
bind dist_config_id_regs dist_config_id_regs_sva #(.a3v_cfg(a3v_cfg), .lpi_cfg(lpi_cfg), .two_sec_cfg(two_sec_cfg),
    .lines_cfg(lines_cfg)) u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .scrub_enable);

/* verification/tb_dist_config_id_regs.sv */
`timescale 1ns/100ps
module tb_dist_config_id_regs;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, scrub_enable, err;
    int num_errors = 0, tests_run = 0;
    dist_config_id_regs #(.security_disable_param(dist_id_pkg::ds_prog)) u_dist_config_id_regs (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scrub_enable);
    initial forever #2.5 pclk = ~pclk;
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    // leaves psel high so consecutive calls run back to back
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rdat = prdata;
        err = pslverr;
        if (n >= 16) begin
            num_errors++;
            stop_test();
        end
    endtask : xfer
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        xfer(1'h0, dist_id_pkg::ctrl_addr, 32'h0);
        chk(rdat, 32'h00000030);
        xfer(1'h0, dist_id_pkg::type_addr, 32'h0);
        chk(rdat, 32'h007b041f);
        xfer(1'h1, dist_id_pkg::type_addr, 32'hffffffff);
        xfer(1'h0, dist_id_pkg::type_addr, 32'h0);
        chk(rdat, 32'h007b041f);
        xfer(1'h1, dist_id_pkg::iid_addr, 32'hffffffff);
        xfer(1'h0, dist_id_pkg::iid_addr, 32'h0);
        chk(rdat, 32'h5a0027e5);
        xfer(1'h0, 16'h0010, 32'h0);
        chk({31'h0, err}, 32'h1);
        xfer(1'h1, dist_id_pkg::ctrl_addr, 32'h00000040);
        xfer(1'h0, dist_id_pkg::ctrl_addr, 32'h0);
        chk(rdat, 32'h00000070);
        xfer(1'h0, dist_id_pkg::type_addr, 32'h0);
        chk(rdat, 32'h007b001f);
        xfer(1'h1, dist_id_pkg::fctl_addr, 32'h1);
        xfer(1'h0, dist_id_pkg::fctl_addr, 32'h0);
        chk(rdat, 32'h1);
        chk({31'h0, scrub_enable}, 32'h1);
        xfer(1'h1, dist_id_pkg::fctl_addr, 32'h0);
        xfer(1'h0, dist_id_pkg::ctrl_addr, 32'h0);
        chk({31'h0, scrub_enable}, 32'h0);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
        stop_test();
    end
endmodule : tb_dist_config_id_regs
